// *** pkg/ratc_pkg.sv ***
// Purpose: shared constants for the rheostat auto-trim control
// Assumes: one system clock at 25 MHz, register port with one-cycle read latency
// Notes: register offsets are word indices on the plain register port
package ratc_pkg;
   localparam int RATC_CNT_W = 10;
   localparam logic [9:0] RATC_CNT_MAX = 10'h3ff;
   localparam logic [9:0] RATC_CNT_MIN = 10'h000;
   localparam logic [9:0] RATC_CNT_RST = 10'h200;
   localparam int RATC_ADDR_W = 4;
   localparam int RATC_DATA_W = 32;
   localparam logic [3:0] RATC_REG_CTRL = 4'h0;
   localparam logic [3:0] RATC_REG_DIV = 4'h1;
   localparam logic [3:0] RATC_REG_STAT = 4'h2;
   localparam logic [3:0] RATC_REG_VAL0 = 4'h3;
   localparam logic [3:0] RATC_REG_VAL1 = 4'h4;
   // control register bit positions
   localparam int RATC_B_EN0 = 0;
   localparam int RATC_B_EN1 = 1;
   localparam int RATC_B_INV = 2;
   localparam int RATC_B_EXTCLK = 3;
   localparam int RATC_DIV_W = 16;
   localparam logic [15:0] RATC_DIV_RST = 16'h0018;
   // number of rheostat units
   localparam int RATC_UNITS = 2;
   typedef enum logic [1:0] {RATC_IDLE, RATC_RUN, RATC_HOLD} ratc_state_type;
endpackage : ratc_pkg

// *** design/ratc_clkdiv.sv ***
// Purpose: internal trim clock divider, one-cycle enable pulse
// Assumes: runs only while enable is high, restarts when enable drops
// Notes: pulse period is div+1 system clocks
`timescale 1ns/100ps
`default_nettype none
module ratc_clkdiv
   import ratc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_en,
   input wire logic [RATC_DIV_W-1:0] i_div,
   output logic o_tick
);
   typedef struct packed {
      logic [RATC_DIV_W-1:0] cnt;
      logic tick;
   } ratc_div_type;
   ratc_div_type s_r;
   ratc_div_type s_nxt;

   // count down and emit a tick at zero
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (!i_en) begin
         s_nxt.cnt = i_div;
      end else if (s_r.cnt == '0) begin
         s_nxt.cnt = i_div;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_tick = s_r.tick;
endmodule : ratc_clkdiv
`default_nettype wire

// *** design/ratc_top.sv ***
// Function
// - comparator is enabled automatically while a calibration runs
// - trim begins only on a rising edge of the start request
// - start request stays latched until the trim ends
// - start switches on comparator and voltage reference
// - counter steps up or down following count direction
// - trim clock chosen between internal divider and matrix clock
// - internal clock produces pulses by itself while trimming
// - each trim clock rising edge moves counter one step
// - stop when count direction changes at a clock edge
// - stop at upper limit without wrapping
// - stop at lower limit without wrapping
// - any stop toggles idle status and resets sequencing
// - start still high keeps trimming around the set point
// - comparator polarity selectable inverting or non-inverting
// - comparator channel follows whichever unit's start is latched
// - auto-trim enabled per rheostat by its own setting
//
// Purpose: auto-trim sequencer for two digital rheostats
// Assumes: pins from outside pass two flip-flops; matrix clock sampled as a level
// Notes: trim clock domain is the system clock gated by a one-cycle trim tick
`timescale 1ns/100ps
`default_nettype none
module ratc_top
   import ratc_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic [RATC_UNITS-1:0] I_TRIM_START_REQUEST,
   input wire logic I_COMPARATOR_OUT,
   input wire logic I_MATRIX_CLK,
   input wire logic [RATC_ADDR_W-1:0] I_ADDR,
   input wire logic [RATC_DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [RATC_DATA_W-1:0] O_RDATA,
   output logic O_COMP_EN,
   output logic O_VREF_EN,
   output logic O_CHANNEL_SEL,
   output logic [RATC_UNITS-1:0] O_TRIM_IDLE_STATUS,
   output logic [RATC_CNT_W-1:0] O_RHEO0,
   output logic [RATC_CNT_W-1:0] O_RHEO1
);
   typedef struct packed {
      logic [RATC_UNITS-1:0] start_s1;
      logic [RATC_UNITS-1:0] start_s2;
      logic cmp_s1;
      logic cmp_s2;
      logic mclk_s1;
      logic mclk_s2;
      logic mclk_d;
      logic [RATC_UNITS-1:0] start_prev;
      logic [RATC_UNITS-1:0] latched;
      ratc_state_type state;
      logic unit;
      logic dir_prev;
      logic first;
      logic [RATC_CNT_W-1:0] cnt0;
      logic [RATC_CNT_W-1:0] cnt1;
      logic [RATC_UNITS-1:0] idle;
      logic en0;
      logic en1;
      logic inv;
      logic extclk;
      logic [RATC_DIV_W-1:0] div;
      logic [RATC_DATA_W-1:0] rdata;
      logic comp_en;
      logic vref_en;
      logic chan;
   } ratc_top_type;

   ratc_top_type s_r;
   ratc_top_type s_nxt;
   logic int_tick;
   logic trim_tick;
   logic dir;
   logic [RATC_CNT_W-1:0] cur;

   // saturating single step of the counter
   function automatic logic [RATC_CNT_W-1:0] ratc_step(input logic [RATC_CNT_W-1:0] v, input logic up);
      if (up) begin
         ratc_step = (v == RATC_CNT_MAX) ? v : v + 1'b1;
      end else begin
         ratc_step = (v == RATC_CNT_MIN) ? v : v - 1'b1;
      end
   endfunction : ratc_step

   // internal divider runs while a unit is armed or a trim is under way;
   // gating it to run only would leave hold stuck and never see a start edge
   ratc_clkdiv u_div (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_en(!s_r.extclk && (s_r.state != RATC_IDLE || s_r.en0 || s_r.en1)),
      .i_div(s_r.div),
      .o_tick(int_tick)
   );

   // trim clock select: matrix edge or internal tick
   assign trim_tick = s_r.extclk ? (s_r.mclk_s2 && !s_r.mclk_d) : int_tick;
   assign dir = s_r.cmp_s2 ^ s_r.inv;
   assign cur = s_r.unit ? s_r.cnt1 : s_r.cnt0;

   // sequencer, synchronisers and register port
   always_comb begin
      s_nxt = s_r;
      s_nxt.start_s1 = I_TRIM_START_REQUEST;
      s_nxt.start_s2 = s_r.start_s1;
      s_nxt.cmp_s1 = I_COMPARATOR_OUT;
      s_nxt.cmp_s2 = s_r.cmp_s1;
      s_nxt.mclk_s1 = I_MATRIX_CLK;
      s_nxt.mclk_s2 = s_r.mclk_s1;
      s_nxt.mclk_d = s_r.mclk_s2;
      s_nxt.rdata = '0;
      if (trim_tick) begin
         s_nxt.start_prev = s_r.start_s2;
      end
      unique case (s_r.state)
         RATC_IDLE: begin
            if (trim_tick) begin
               // rising edge of an enabled unit's start; unit 0 wins a tie
               if (s_r.start_s2[0] && !s_r.start_prev[0] && s_r.en0) begin
                  s_nxt.latched = 2'b01;
                  s_nxt.unit = 1'b0;
                  s_nxt.state = RATC_RUN;
               end else if (s_r.start_s2[1] && !s_r.start_prev[1] && s_r.en1) begin
                  s_nxt.latched = 2'b10;
                  s_nxt.unit = 1'b1;
                  s_nxt.state = RATC_RUN;
               end
               if (s_nxt.state == RATC_RUN) begin
                  s_nxt.first = 1'b1;
                  s_nxt.comp_en = 1'b1;
                  s_nxt.vref_en = 1'b1;
                  s_nxt.chan = s_nxt.unit;
                  s_nxt.idle[s_nxt.unit] = 1'b0;
               end
            end
         end
         RATC_RUN: begin
            if (trim_tick) begin
               s_nxt.first = 1'b0;
               s_nxt.dir_prev = dir;
               if (s_r.unit) begin
                  s_nxt.cnt1 = ratc_step(s_r.cnt1, dir);
               end else begin
                  s_nxt.cnt0 = ratc_step(s_r.cnt0, dir);
               end
               // direction flip or limit reached ends the trim
               if ((!s_r.first && dir != s_r.dir_prev) ||
                   (dir && cur == RATC_CNT_MAX) || (!dir && cur == RATC_CNT_MIN)) begin
                  s_nxt.idle[s_r.unit] = 1'b1;
                  s_nxt.state = RATC_HOLD;
               end
            end
         end
         RATC_HOLD: begin
            // sequencing reset; a held start restarts the trim
            s_nxt.first = 1'b1;
            if (trim_tick) begin
               if (s_r.start_s2[s_r.unit]) begin
                  s_nxt.idle[s_r.unit] = 1'b0;
                  s_nxt.state = RATC_RUN;
               end else begin
                  s_nxt.latched = '0;
                  s_nxt.comp_en = 1'b0;
                  s_nxt.vref_en = 1'b0;
                  s_nxt.state = RATC_IDLE;
               end
            end
         end
      endcase
      // register port
      if (I_WR) begin
         unique case (I_ADDR)
            RATC_REG_CTRL: begin
               s_nxt.en0 = I_WDATA[RATC_B_EN0];
               s_nxt.en1 = I_WDATA[RATC_B_EN1];
               s_nxt.inv = I_WDATA[RATC_B_INV];
               s_nxt.extclk = I_WDATA[RATC_B_EXTCLK];
            end
            RATC_REG_DIV: s_nxt.div = I_WDATA[RATC_DIV_W-1:0];
            default: ;
         endcase
      end
      if (I_RD) begin
         unique case (I_ADDR)
            RATC_REG_CTRL: s_nxt.rdata = {28'h0000000, s_r.extclk, s_r.inv, s_r.en1, s_r.en0};
            RATC_REG_DIV: s_nxt.rdata = {16'h0000, s_r.div};
            RATC_REG_STAT: s_nxt.rdata = {26'h0000000, s_r.latched, s_r.idle, s_r.comp_en, s_r.state == RATC_RUN};
            RATC_REG_VAL0: s_nxt.rdata = {22'h000000, s_r.cnt0};
            RATC_REG_VAL1: s_nxt.rdata = {22'h000000, s_r.cnt1};
            default: s_nxt.rdata = '0;
         endcase
      end
   end

   // state register
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         s_r <= '0;
         s_r.state <= RATC_IDLE;
         s_r.cnt0 <= RATC_CNT_RST;
         s_r.cnt1 <= RATC_CNT_RST;
         s_r.idle <= 2'b11;
         s_r.div <= RATC_DIV_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign O_RDATA = s_r.rdata;
   assign O_COMP_EN = s_r.comp_en;
   assign O_VREF_EN = s_r.vref_en;
   assign O_CHANNEL_SEL = s_r.chan;
   assign O_TRIM_IDLE_STATUS = s_r.idle;
   assign O_RHEO0 = s_r.cnt0;
   assign O_RHEO1 = s_r.cnt1;

   // comparator on whenever a unit is latched
   a_comp_on_latch: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      (s_r.latched != '0) |-> O_COMP_EN && O_VREF_EN) else $error("comparator off during trim");
   // unit 0 counter never wraps at the top
   a_no_wrap_hi: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      ($past(O_RHEO0) == RATC_CNT_MAX) |-> (O_RHEO0 != RATC_CNT_MIN)) else $error("counter wrapped high");
   // unit 0 counter never wraps at the bottom
   a_no_wrap_lo: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      ($past(O_RHEO0) == RATC_CNT_MIN) |-> (O_RHEO0 != RATC_CNT_MAX)) else $error("counter wrapped low");
   // counter only moves on a trim tick
   a_step_tick: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      (!trim_tick && s_r.state == RATC_RUN) |=> $stable(O_RHEO0) && $stable(O_RHEO1)) else $error("step without tick");
   // unit 0 steps up by one on a trim tick when the count direction is up
   a_step_dir: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      (trim_tick && s_r.state == RATC_RUN && !s_r.unit && dir && s_r.cnt0 != RATC_CNT_MAX)
      |=> O_RHEO0 == $past(s_r.cnt0) + 10'h001) else $error("wrong step direction");
   // direction flip stops the trim
   a_flip_stop: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      (trim_tick && s_r.state == RATC_RUN && !s_r.first && dir != s_r.dir_prev)
      |=> s_r.state == RATC_HOLD && O_TRIM_IDLE_STATUS[$past(s_r.unit)]) else $error("flip did not stop");
   // channel follows the latched unit
   a_chan_unit: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      (s_r.latched == 2'b10) |-> O_CHANNEL_SEL) else $error("wrong channel");
   // disabled unit never starts
   a_unit_en: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      (s_r.state == RATC_IDLE && !s_r.en0 && !s_r.en1) |=> s_r.state == RATC_IDLE) else $error("disabled unit started");
   // running unit shows active status
   a_run_active: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
      (s_r.state == RATC_RUN) |-> !O_TRIM_IDLE_STATUS[s_r.unit]) else $error("idle during trim");
endmodule : ratc_top
`default_nettype wire

// *** tb/ratc_partner.sv ***
// Purpose: comparator and rheostat feedback seen by the trim sequencer
// Assumes: comparator output is high while the selected rheostat sits below its set point
// Notes: a disabled comparator shows the inverse of its last level
`timescale 1ns/100ps
`default_nettype none
module ratc_partner (
   input wire logic i_clk,
   input wire logic i_comp_en,
   input wire logic i_chan,
   input wire logic [9:0] i_rheo0,
   input wire logic [9:0] i_rheo1,
   input wire logic [10:0] i_sp0,
   input wire logic [10:0] i_sp1,
   output logic o_cmp
);
   logic last_r = 1'b0;
   logic up;
   // compare the channel of the latched unit; set point one bit wider so
   // a point above the top code keeps the comparator high at the limit
   assign up = i_chan ? ({1'b0, i_rheo1} < i_sp1) : ({1'b0, i_rheo0} < i_sp0);
   always @(posedge i_clk) last_r <= o_cmp;
   // powered down: output no longer holds a valid level
   assign o_cmp = i_comp_en ? up : ~last_r;
endmodule : ratc_partner
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: scenario bench for the rheostat auto-trim sequencer
// Assumes: matrix clock drives most scenarios, one runs on the internal divider alone
// Notes: one task per scenario, each judges its own results
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import ratc_pkg::*;
   logic clk, rst, wr, rd, mclk, cmp, comp_en, vref_en, chan;
   logic [1:0] start, idle;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [9:0] rheo0, rheo1;
   logic [10:0] sp0, sp1;
   int error_cnt = 0;
   int tests_run = 0;

   ratc_top DUT (.I_CLK(clk), .I_SYS_RST(rst), .I_TRIM_START_REQUEST(start), .I_COMPARATOR_OUT(cmp),
      .I_MATRIX_CLK(mclk), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .O_COMP_EN(comp_en), .O_VREF_EN(vref_en), .O_CHANNEL_SEL(chan), .O_TRIM_IDLE_STATUS(idle),
      .O_RHEO0(rheo0), .O_RHEO1(rheo1));
   ratc_partner u_far (.i_clk(clk), .i_comp_en(comp_en), .i_chan(chan), .i_rheo0(rheo0),
      .i_rheo1(rheo1), .i_sp0(sp0), .i_sp1(sp1), .o_cmp(cmp));

   // system clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask : chk

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp, input string name);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(name, exp, rdata);
   endtask : rd_reg

   // one matrix clock pulse, spaced wide enough for the comparator to settle
   task automatic tick();
      @(posedge clk);
      mclk <= 1'b1;
      repeat (3) @(posedge clk);
      mclk <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : tick

   // fresh start edge, then ticks until the unit reports idle
   task automatic run(input int u, input int n);
      int k;
      start[u] <= 1'b0;
      tick();
      start[u] <= 1'b1;
      tick();
      chk("comp_en", 1, comp_en);
      chk("vref_en", 1, vref_en);
      chk("channel", u, chan);
      chk("active", 0, idle[u]);
      start[u] <= 1'b0;
      tick();
      chk("latched", 1, comp_en);
      start[u] <= 1'b1;
      k = 0;
      while (idle[u] !== 1'b1 && k < n) begin
         tick();
         k++;
      end
      if (idle[u] !== 1'b1) begin
         chk("run done", 1, idle[u]);
         stop_test();
      end
   endtask : run

   // drop start, then tick until the sequencer lets go of the comparator
   task automatic release_unit(input int u);
      int k;
      start[u] <= 1'b0;
      k = 0;
      while (comp_en !== 1'b0 && k < 8) begin
         tick();
         k++;
      end
      chk("comp off", 0, comp_en);
      chk("idle", 1, idle[u]);
   endtask : release_unit

   task automatic t_reset_vals();
      rd_reg(RATC_REG_CTRL, 32'h0, "ctrl");
      rd_reg(RATC_REG_DIV, 32'h18, "div");
      rd_reg(RATC_REG_VAL0, 32'h200, "val0");
      rd_reg(RATC_REG_VAL1, 32'h200, "val1");
      rd_reg(4'hf, 32'h0, "unmapped");
      rd_reg(RATC_REG_STAT, 32'hc, "stat rst");
      chk("idle rst", 2'b11, idle);
      chk("comp rst", 0, comp_en);
   endtask : t_reset_vals

   task automatic t_disabled_unit();
      wr_reg(RATC_REG_CTRL, 32'h8);
      tick();
      start[0] <= 1'b1;
      repeat (3) tick();
      chk("no trim idle", 2'b11, idle);
      chk("no trim comp", 0, comp_en);
      start[0] <= 1'b0;
   endtask : t_disabled_unit

   task automatic t_set_point();
      wr_reg(RATC_REG_CTRL, 32'h9);
      sp0 = 11'h205;
      run(0, 20);
      chk("near set point", 1, rheo0 >= 10'h204 && rheo0 <= 10'h206);
      tick();
      chk("rerun held", 0, idle[0]);
      release_unit(0);
   endtask : t_set_point

   task automatic t_upper();
      sp0 = 11'h400;
      run(0, 600);
      chk("upper", 10'h3ff, rheo0);
      rd_reg(RATC_REG_STAT, 32'h1e, "stat hold");
      release_unit(0);
      rd_reg(RATC_REG_VAL0, 32'h3ff, "val0 kept");
   endtask : t_upper

   task automatic t_lower_inv();
      wr_reg(RATC_REG_CTRL, 32'he);
      sp1 = 11'h3ff;
      run(1, 600);
      chk("lower", 10'h0, rheo1);
      release_unit(1);
      chk("unit0 kept", 10'h3ff, rheo0);
   endtask : t_lower_inv

   // internal divider alone paces the trim, matrix clock stays still
   task automatic t_internal();
      int k;
      wr_reg(RATC_REG_CTRL, 32'h1);
      sp0 = 11'h3fd;
      start[0] <= 1'b1;
      k = 0;
      while (idle[0] !== 1'b0 && k < 100) begin
         @(posedge clk);
         k++;
      end
      chk("int started", 0, idle[0]);
      start[0] <= 1'b0;
      k = 0;
      while (comp_en !== 1'b0 && k < 400) begin
         @(posedge clk);
         k++;
      end
      chk("int comp off", 0, comp_en);
      chk("int idle", 1, idle[0]);
      chk("int trimmed", 1, rheo0 >= 10'h3fc && rheo0 <= 10'h3fe);
   endtask : t_internal

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      mclk = 1'b0;
      start = 2'b00;
      addr = 4'h0;
      wdata = 32'h0;
      sp0 = 11'h0;
      sp1 = 11'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset_vals();
      t_disabled_unit();
      t_set_point();
      t_upper();
      t_lower_inv();
      t_internal();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
